// [core/ufs_user.sv]
// user-side interface logic: parallel requests to the serial flash link
// assumes the store end is attached through ufs_link_if on the same clock
`timescale 1ns/10ps
module ufs_user
    import ufs_pkg::*;
#(
    parameter int DIV = UFS_HOST_DIV
) (
    // clock and reset
    input  wire logic CLK,
    input  wire logic RST_N,
    // serial link to the store
    ufs_link_if.user LINK,
    // user command port
    input  wire logic        CMD_VALID,
    input  wire logic [1:0]  CMD_OP,
    input  wire logic [8:0]  CMD_ADDR,
    input  wire logic [15:0] CMD_WDATA,
    output logic             CMD_READY,
    output logic             RD_VALID,
    output logic      [15:0] RD_DATA
);
    initial begin
        if (DIV < 1 || DIV > 255)
            $error("ufs_user: DIV out of range");
    end

    // commands: 0 read at address, 1 read next, 2 program, 3 erase sector
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_NEXT = 2'h1;
    localparam logic [1:0] OP_PROG = 2'h2;

    typedef enum logic [2:0] {U_IDLE, U_ADDR, U_INC, U_LOAD, U_SHIFT, U_REQ} ufs_ust_t;

    typedef struct packed {
        ufs_ust_t    st;
        logic [7:0]  div;
        logic [4:0]  n;
        logic [1:0]  op;
        logic [8:0]  asr;
        logic [15:0] wsr;
        logic [15:0] rsr;
        logic        asel, aclk, ain, dsel, dclk, din, preq, ereq;
        logic        ready, rvalid;
        logic [15:0] rdata;
    } ufs_user_t;

    ufs_user_t u_q;
    ufs_user_t u_d;
    logic      tick;

    //------------------------------------------------------------
    // sequencer; link pulses only on divider ticks
    //------------------------------------------------------------
    always_comb begin
        u_d        = u_q;
        u_d.aclk   = 1'b0;
        u_d.dclk   = 1'b0;
        u_d.rvalid = 1'b0;
        tick       = (u_q.div == 8'(DIV - 1));
        u_d.div    = tick ? 8'h00 : u_q.div + 8'h01;
        case (u_q.st)
            U_IDLE: begin
                // select drops between transfers so each window frames one word
                u_d.dsel  = 1'b0;
                u_d.ready = 1'b1;
                if (CMD_VALID && u_q.ready && !LINK.busy) begin
                    u_d.ready = 1'b0;
                    u_d.op    = CMD_OP;
                    u_d.asr   = CMD_ADDR;
                    u_d.wsr   = CMD_WDATA;
                    u_d.n     = 5'(UFS_ADDR_W);
                    u_d.st    = (CMD_OP == OP_NEXT) ? U_INC : U_ADDR;
                end
            end
            U_ADDR: if (tick) begin
                u_d.asel = 1'b1;
                u_d.aclk = 1'b1;
                u_d.ain  = u_q.asr[8]; // msb first
                u_d.asr  = {u_q.asr[7:0], 1'b0};
                u_d.n    = u_q.n - 5'h01;
                if (u_q.n == 5'h01) begin
                    u_d.n  = 5'(UFS_DATA_W);
                    u_d.st = (u_q.op == OP_READ) ? U_LOAD : U_SHIFT;
                    u_d.dsel = (u_q.op == OP_PROG);
                end
            end
            U_INC: if (tick) begin
                u_d.asel = 1'b0;
                u_d.aclk = 1'b1;
                u_d.n    = 5'(UFS_DATA_W);
                u_d.st   = U_LOAD;
            end
            U_LOAD: if (tick) begin
                u_d.asel = 1'b0;
                u_d.dsel = 1'b0;
                u_d.dclk = 1'b1; // parallel load of the addressed word
                u_d.st   = U_SHIFT;
                u_d.rsr  = '0;
            end
            U_SHIFT: if (tick) begin
                u_d.asel = 1'b0;
                u_d.dsel = 1'b1;
                u_d.dclk = 1'b1;
                u_d.din  = u_q.wsr[15];
                u_d.wsr  = {u_q.wsr[14:0], 1'b0};
                // capture before the edge that advances the shifter
                u_d.rsr  = {u_q.rsr[14:0], LINK.data_serial_out};
                u_d.n    = u_q.n - 5'h01;
                if (u_q.n == 5'h01) begin
                    if (u_q.op[1]) begin
                        u_d.st   = U_REQ;
                        u_d.preq = (u_q.op == OP_PROG);
                        u_d.ereq = (u_q.op != OP_PROG); // one sector per request
                    end else begin
                        u_d.st     = U_IDLE;
                        u_d.rvalid = 1'b1;
                        u_d.rdata  = {u_q.rsr[14:0], LINK.data_serial_out};
                    end
                end
            end
            U_REQ: begin
                u_d.dsel = 1'b0;
                // hold the request until busy falls after having risen
                if (u_q.n == 5'h00 && LINK.busy)
                    u_d.n = 5'h01;
                if (u_q.n == 5'h01 && !LINK.busy) begin
                    u_d.preq = 1'b0;
                    u_d.ereq = 1'b0;
                    u_d.st   = U_IDLE;
                end
            end
            default: u_d.st = U_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            u_q    <= '0;
            u_q.st <= U_IDLE;
        end else begin
            u_q <= u_d;
        end
    end

    //------------------------------------------------------------
    // outputs from flip-flops
    //------------------------------------------------------------
    assign LINK.addr_shift_select   = u_q.asel;
    assign LINK.address_shift_clock = u_q.aclk;
    assign LINK.addr_serial_in      = u_q.ain;
    assign LINK.data_shift_select   = u_q.dsel;
    assign LINK.data_shift_clock    = u_q.dclk;
    assign LINK.data_serial_in      = u_q.din;
    assign LINK.program_req         = u_q.preq;
    assign LINK.erase_req           = u_q.ereq;
    assign CMD_READY                = u_q.ready;
    assign RD_VALID                 = u_q.rvalid;
    assign RD_DATA                  = u_q.rdata;
endmodule

// [core/ufs_pkg.sv]
// package for the user flash serial access block
// assumes a single 10 MHz system clock shared by both ends
package ufs_pkg;
    localparam int          UFS_ADDR_W      = 9;
    localparam int          UFS_DATA_W      = 16;
    localparam int          UFS_WORDS       = 512;
    localparam logic [8:0]  UFS_ADDR_TOP    = 9'h1ff;
    localparam logic [8:0]  UFS_SEC0_TOP    = 9'h0ff;
    localparam logic [8:0]  UFS_SEC1_BASE   = 9'h100;
    localparam int          UFS_SECTOR_BIT  = 8;
    localparam logic [15:0] UFS_ERASED_WORD = 16'hffff;
    localparam int          UFS_OSC_DIV     = 4;
    // clock and oscillator rates in kHz
    localparam int          UFS_CLK_KHZ     = 10000;
    localparam int          UFS_OSC_KHZ     = 16000;
    // output toggle rate: two toggles per divided period, kept below the clock rate
    localparam int          UFS_OSC_STEP    = 2 * UFS_OSC_KHZ / UFS_OSC_DIV;
    // internal algorithm times in microseconds
    localparam int          UFS_PROG_US     = 2;
    localparam int          UFS_ERASE_US    = 20;
    localparam int          UFS_PROG_CYC    = (UFS_PROG_US * UFS_CLK_KHZ + 999) / 1000;
    localparam int          UFS_ERASE_CYC   = (UFS_ERASE_US * UFS_CLK_KHZ + 999) / 1000;
    localparam int          UFS_CNT_W       = 16;
    // divider for the host serial clock enables
    localparam int          UFS_HOST_DIV    = 2;
endpackage

// [core/ufs_link_if.sv]
// serial link between the flash store and the user logic
// assumes both ends run on the same clock; shift clocks are enable pulses
`timescale 1ns/10ps
interface ufs_link_if;
    logic addr_shift_select;
    logic address_shift_clock;
    logic addr_serial_in;
    logic data_shift_select;
    logic data_shift_clock;
    logic data_serial_in;
    logic data_serial_out;
    logic program_req;
    logic erase_req;
    logic busy;
    logic divided_oscillator_out;
    modport store (
        input  addr_shift_select, address_shift_clock, addr_serial_in,
        input  data_shift_select, data_shift_clock, data_serial_in,
        input  program_req, erase_req,
        output data_serial_out, busy, divided_oscillator_out
    );
    modport user (
        output addr_shift_select, address_shift_clock, addr_serial_in,
        output data_shift_select, data_shift_clock, data_serial_in,
        output program_req, erase_req,
        input  data_serial_out, busy, divided_oscillator_out
    );
endinterface

// [core/ufs_store.sv]
// user flash store: 512 x 16 words, two sectors, serial address and data
// assumes the user end drives the link with enable pulses on CLK
`timescale 1ns/10ps
// Overview of operation
// - 512 words, nine bit address 000h-1FFh
// - low half sector zero, upper half one
// - each word holds sixteen bits
// - erase clears exactly one sector
// - user erases before programming; other sector kept
// - own oscillator, divided by four output
// - divided output fixed, about 3.9-5.3 MHz
// - requests run internal algorithm, busy meanwhile
// - user holds request until busy drops
// - single reads and auto-increment stream reads
// - shift clock without select increments address
// - nine bit address, sixteen bit data shifters
// - test port also programs and reads
module ufs_store
    import ufs_pkg::*;
#(
    parameter int PROG_CYC  = UFS_PROG_CYC,
    parameter int ERASE_CYC = UFS_ERASE_CYC
) (
    // clock and reset
    input  wire logic CLK,
    input  wire logic RST_N,
    // serial link to user logic
    ufs_link_if.store LINK,
    // test port access, parallel
    input  wire logic        TEST_WR,
    input  wire logic        TEST_RD,
    input  wire logic [8:0]  TEST_ADDR,
    input  wire logic [15:0] TEST_WDATA,
    output logic      [15:0] TEST_RDATA
);
    initial begin
        if (PROG_CYC < 1 || ERASE_CYC < 1 || ERASE_CYC >= 2**UFS_CNT_W)
            $error("ufs_store: bad algorithm cycle count");
        if (UFS_OSC_STEP >= UFS_CLK_KHZ)
            $error("ufs_store: oscillator too fast for the clock");
    end

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE, ST_DONE} ufs_op_t;

    typedef struct packed {
        logic [UFS_WORDS-1:0][15:0] mem;
        logic [8:0]                 addr;
        logic [15:0]                dsr;
        ufs_op_t                    op;
        logic [UFS_CNT_W-1:0]       cnt;
        logic                       busy;
        logic [15:0]                phase;
        logic                       osc;
        logic [15:0]                trd;
    } ufs_store_t;

    ufs_store_t s_q;
    ufs_store_t s_d;

    function automatic logic ufs_sector(input logic [8:0] a);
        return a[UFS_SECTOR_BIT];
    endfunction

    //------------------------------------------------------------
    // next state
    //------------------------------------------------------------
    always_comb begin
        logic [16:0] ph;
        ph  = '0;
        s_d = s_q;
        // oscillator model: accumulator toggles at twice the divided rate, so the
        // output averages the quarter oscillator rate with one clock of jitter
        ph = {1'b0, s_q.phase} + 17'(UFS_OSC_STEP);
        if (ph >= 17'(UFS_CLK_KHZ)) begin
            s_d.phase = 16'(ph - 17'(UFS_CLK_KHZ));
            s_d.osc   = ~s_q.osc; // fixed rate, no control input
        end else begin
            s_d.phase = ph[15:0];
        end
        // address register: shift or auto-increment, refused while busy
        if (LINK.address_shift_clock && s_q.op == ST_IDLE) begin
            if (LINK.addr_shift_select)
                s_d.addr = {s_q.addr[7:0], LINK.addr_serial_in};
            else
                s_d.addr = s_q.addr + 9'h001; // wraps 1FFh to 000h
        end
        // data register: parallel load from array or serial shift
        if (LINK.data_shift_clock && s_q.op == ST_IDLE) begin
            if (LINK.data_shift_select)
                s_d.dsr = {s_q.dsr[14:0], LINK.data_serial_in};
            else
                s_d.dsr = s_q.mem[s_q.addr];
        end
        // program and erase algorithm
        case (s_q.op)
            ST_IDLE: begin
                if (LINK.erase_req) begin
                    s_d.op   = ST_ERASE;
                    s_d.cnt  = UFS_CNT_W'(ERASE_CYC - 1);
                    s_d.busy = 1'b1;
                end else if (LINK.program_req) begin
                    s_d.op   = ST_PROG;
                    s_d.cnt  = UFS_CNT_W'(PROG_CYC - 1);
                    s_d.busy = 1'b1;
                end
            end
            ST_PROG: begin
                if (s_q.cnt == '0) begin
                    // flash bits only clear; unerased cells keep zeros it cannot set
                    s_d.mem[s_q.addr] = s_q.mem[s_q.addr] & s_q.dsr;
                    s_d.op   = ST_DONE;
                    s_d.busy = 1'b0;
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
            ST_ERASE: begin
                if (s_q.cnt == '0) begin
                    for (int i = 0; i < UFS_WORDS; i++) begin
                        if (ufs_sector(9'(i)) == ufs_sector(s_q.addr))
                            s_d.mem[i] = UFS_ERASED_WORD;
                    end
                    s_d.op   = ST_DONE;
                    s_d.busy = 1'b0;
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
            ST_DONE: begin
                // wait for request release so one hold does not rerun
                if (!LINK.program_req && !LINK.erase_req)
                    s_d.op = ST_IDLE;
            end
            default: s_d.op = ST_IDLE;
        endcase
        // test port, only while the serial side is idle
        if (s_q.op == ST_IDLE && !LINK.program_req && !LINK.erase_req) begin
            if (TEST_WR)
                s_d.mem[TEST_ADDR] = s_q.mem[TEST_ADDR] & TEST_WDATA;
            if (TEST_RD)
                s_d.trd = s_q.mem[TEST_ADDR];
        end
    end

    //------------------------------------------------------------
    // registers; reset loads the whole array erased, every word FFFFh
    //------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q      <= '0;
            s_q.mem  <= {UFS_WORDS{UFS_ERASED_WORD}};
            s_q.op   <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    //------------------------------------------------------------
    // outputs, all from flip-flops
    //------------------------------------------------------------
    assign LINK.data_serial_out        = s_q.dsr[15];
    assign LINK.busy                   = s_q.busy;
    assign LINK.divided_oscillator_out = s_q.osc;
    assign TEST_RDATA                  = s_q.trd;
endmodule

// [verification/ufs_link_checker.sv]
// concurrent checks on the serial link between the store and user ends
// assumes every link signal is registered on CLK and RST_N is async low
`timescale 1ns/10ps
module ufs_link_checker
    import ufs_pkg::*;
#(
    parameter int PROG_CYC  = UFS_PROG_CYC,
    parameter int ERASE_CYC = UFS_ERASE_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // link from the user end
    input wire logic addr_shift_select,
    input wire logic address_shift_clock,
    input wire logic data_shift_select,
    input wire logic data_shift_clock,
    input wire logic program_req,
    input wire logic erase_req,
    // link from the store end
    input wire logic data_serial_out,
    input wire logic busy,
    input wire logic divided_oscillator_out
);
    logic [4:0]  acnt_q;
    logic [4:0]  dcnt_q;
    logic [15:0] len_q;

    // ------------------------------------
    // helper counters
    // ------------------------------------
    // shift pulses per select window, busy cycles per operation
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            acnt_q <= 5'h00;
            dcnt_q <= 5'h00;
            len_q  <= 16'h0000;
        end else begin
            acnt_q <= !addr_shift_select ? 5'h00 : acnt_q + 5'(address_shift_clock);
            dcnt_q <= !data_shift_select ? 5'h00 : dcnt_q + 5'(data_shift_clock);
            len_q  <= busy ? len_q + 16'h0001 : 16'h0000;
        end
    end

    // ------------------------------------
    // assertions
    // ------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // a fresh request seen by an idle store, and the end of the algorithm
    sequence req_start;
        $rose(program_req || erase_req) && !busy;
    endsequence
    sequence busy_done;
        $fell(busy);
    endsequence

    busy_rise_a: assert property (req_start |-> ##[1:2] busy)
        else $error("busy did not follow a request");
    busy_len_a: assert property (busy_done |-> len_q == PROG_CYC || len_q == ERASE_CYC)
        else $error("busy length off");
    busy_hold_a: assert property (busy |-> program_req || erase_req)
        else $error("request dropped while busy");
    req_drop_a: assert property (busy_done |-> ##[0:3] !(program_req || erase_req))
        else $error("request kept after completion");
    no_shift_busy_a: assert property (busy |-> !address_shift_clock && !data_shift_clock)
        else $error("shift pulse while busy");
    addr_count_a: assert property ($fell(addr_shift_select) |-> acnt_q == 5'd9)
        else $error("address shift count not nine");
    data_count_a: assert property ($fell(data_shift_select) |-> dcnt_q == 5'd16)
        else $error("data shift count not sixteen");
    aclk_pulse_a: assert property (address_shift_clock |=> !address_shift_clock)
        else $error("address shift pulse too long");
    osc_run_a: assert property (1'b1 |-> ##[1:3] $changed(divided_oscillator_out))
        else $error("oscillator output stalled");
    sout_cause_a: assert property ($changed(data_serial_out) |-> $past(data_shift_clock))
        else $error("serial out moved without a shift");
endmodule

// [verification/user_flash_serial_access_tb.sv]
// testbench: store and user ends joined by the link, against a word model
// assumes the package, interface and both design modules are compiled first
`timescale 1ns/10ps
module user_flash_serial_access_tb;
    import ufs_pkg::*;
    localparam int P_CYC = 3;
    localparam int E_CYC = 7;
    logic        clk;
    logic        rst_n;
    logic        cmd_valid;
    logic [1:0]  cmd_op;
    logic [8:0]  cmd_addr;
    logic [15:0] cmd_wdata;
    logic        cmd_ready;
    logic        rd_valid;
    logic [15:0] rd_data;
    logic        test_wr;
    logic        test_rd;
    logic [8:0]  test_addr;
    logic [15:0] test_wdata;
    logic [15:0] test_rdata;
    logic [15:0] mem [512];
    logic [8:0]  bnd [4] = '{9'h000, 9'h0ff, 9'h100, 9'h1ff};
    logic [31:0] seed;
    int          cur;
    int          mismatches;
    int          samples_checked;

    // ------------------------------------
    // design ends and checker
    // ------------------------------------
    ufs_link_if link ();
    ufs_store #(.PROG_CYC(P_CYC), .ERASE_CYC(E_CYC)) ufs_store_i (
        .CLK(clk), .RST_N(rst_n), .LINK(link), .TEST_WR(test_wr), .TEST_RD(test_rd),
        .TEST_ADDR(test_addr), .TEST_WDATA(test_wdata), .TEST_RDATA(test_rdata));
    ufs_user ufs_user_i (
        .CLK(clk), .RST_N(rst_n), .LINK(link), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready),
        .RD_VALID(rd_valid), .RD_DATA(rd_data));
    ufs_link_checker #(.PROG_CYC(P_CYC), .ERASE_CYC(E_CYC)) ufs_link_checker_i (
        .CLK(clk), .RST_N(rst_n),
        .addr_shift_select(link.addr_shift_select),
        .address_shift_clock(link.address_shift_clock),
        .data_shift_select(link.data_shift_select),
        .data_shift_clock(link.data_shift_clock),
        .program_req(link.program_req), .erase_req(link.erase_req),
        .data_serial_out(link.data_serial_out), .busy(link.busy),
        .divided_oscillator_out(link.divided_oscillator_out));

    // ------------------------------------
    // tasks and model
    // ------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // every drive and sample lands 1 ns after the edge, clear of its updates
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // a wait that runs out counts as a mismatch, so a hang cannot pass
    task automatic to_chk(input int n);
        if (n >= 1000) begin
            mismatches++;
            $display("mismatch at %0t: wait timed out", $time);
        end
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 1000) begin
            tick();
            n++;
        end
        to_chk(n);
    endtask
    // one command: held until the user end takes it, model updated alongside
    task automatic op(input logic [1:0] o, input logic [8:0] a, input logic [15:0] d);
        int n;
        wait_rdy();
        cmd_valid = 1'b1;
        cmd_op = o;
        cmd_addr = a;
        cmd_wdata = d;
        n = 0;
        do begin
            tick();
            n++;
        end while (cmd_ready !== 1'b0 && n < 1000);
        to_chk(n);
        cmd_valid = 1'b0;
        case (o)
            2'd0: cur = a;
            2'd1: cur = (cur + 1) % 512;
            2'd2: begin
                cur = a;
                mem[a] = mem[a] & d;
            end
            default: begin
                cur = a;
                for (int i = 0; i < 256; i++) mem[{a[8], i[7:0]}] = 16'hffff;
            end
        endcase
        if (o < 2'd2) begin
            n = 0;
            do begin
                tick();
                n++;
            end while (rd_valid !== 1'b1 && n < 1000);
            to_chk(n);
            chk(rd_data, mem[cur]);
        end
    endtask
    // test port stands in for the scan path; used only while the link is idle
    task automatic tp_wr(input logic [8:0] a, input logic [15:0] d);
        wait_rdy();
        test_addr = a;
        test_wdata = d;
        test_wr = 1'b1;
        tick();
        test_wr = 1'b0;
        mem[a] = mem[a] & d;
    endtask
    task automatic tp_rd(input logic [8:0] a);
        wait_rdy();
        test_addr = a;
        test_rd = 1'b1;
        tick();
        test_rd = 1'b0;
        tick();
        chk(test_rdata, mem[a]);
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // roughly forty commands of under a hundred cycles each
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        end_sim();
    end
    initial begin
        logic [8:0] a;
        rst_n = 1'b0;
        {cmd_valid, cmd_op, cmd_addr, cmd_wdata} = '0;
        {test_wr, test_rd, test_addr, test_wdata} = '0;
        seed = 32'h87a6135b;
        cur = 0;
        mismatches = 0;
        samples_checked = 0;
        for (int i = 0; i < 512; i++) mem[i] = 16'hffff;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        op(2'd0, 9'h000, 16'h0000);
        op(2'd0, 9'h1ff, 16'h0000);
        for (int k = 0; k < 10; k++) begin
            seed = lfsr(seed);
            a = (k < 4) ? bnd[k] : seed[24:16];
            op(2'd2, a, seed[15:0]);
            op(2'd0, a, 16'h0000);
        end
        seed = lfsr(seed);
        op(2'd2, 9'h0ff, seed[15:0]);
        op(2'd0, 9'h0fe, 16'h0000);
        op(2'd1, 9'h000, 16'h0000);
        op(2'd1, 9'h000, 16'h0000);
        op(2'd0, 9'h1ff, 16'h0000);
        op(2'd1, 9'h000, 16'h0000);
        op(2'd3, 9'h055, 16'h0000);
        op(2'd0, 9'h0ff, 16'h0000);
        op(2'd0, 9'h100, 16'h0000);
        op(2'd3, 9'h1ff, 16'h0000);
        op(2'd0, 9'h1ff, 16'h0000);
        tp_wr(9'h123, seed[31:16]);
        op(2'd0, 9'h123, 16'h0000);
        op(2'd2, 9'h0aa, seed[23:8]);
        tp_rd(9'h0aa);
        wait_rdy();
        end_sim();
    end
endmodule
